/* File: tms_pkg.sv */
// package: modes and timing constants for tx start-up
package tms_pkg;
  // device operating modes
  typedef enum logic [1:0] {
    TMS_MODE_DOWN,
    TMS_MODE_IDLE,
    TMS_MODE_UP
  } tms_mode_t;

  // clock and timing figures
  localparam int TMS_CLK_MHZ = 40;
  localparam int TMS_CLK_DIV = 8;
  localparam int TMS_DIV_W = 3;
  localparam int TMS_LOCK_US = 250;
  localparam int TMS_LOCK_CYC = TMS_LOCK_US * TMS_CLK_MHZ;
  localparam int TMS_XTAL_US = 600;
  localparam int TMS_XTAL_CYC = TMS_XTAL_US * TMS_CLK_MHZ;
  localparam int TMS_CNT_W = 16;
  localparam logic [TMS_DIV_W-1:0] TMS_DIV_RST = 3'h0;
  localparam logic [TMS_CNT_W-1:0] TMS_CNT_RST = 16'h0000;
endpackage

/* File: tms_if.sv */
// interface: control pins between controller and transmitter
`timescale 1ns/1ps
interface tms_if;
  logic pa_keying;
  logic freq_shift;
  logic enable_drv; // enable driven level
  logic enable_oe; // high while controller drives enable
  logic clk_out;
  modport dev (input pa_keying, freq_shift, enable_drv, enable_oe,
    output clk_out);
  modport ctl (output pa_keying, freq_shift, enable_drv, enable_oe,
    input clk_out);
endinterface

/* File: tms_div.sv */
// clock divider: divides crystal-rate enable by eight, aligned start
`timescale 1ns/1ps
module tms_div
  import tms_pkg::*;
#(
  parameter int DIV = TMS_CLK_DIV
) (
  // clock and reset
  input wire logic clk_in,
  input wire logic nrst_in,
  // control
  input wire logic run_in,
  // output
  output logic level_out,
  output logic wrap_out
);
  import tms_pkg::*;
  typedef struct packed {
    logic [TMS_DIV_W-1:0] cnt;
    logic lvl;
  } tms_div_st_t;
  tms_div_st_t st_reg, st_next;

  // count phase, output high for first half period
  always_comb begin
    st_next = st_reg;
    if (!run_in) begin
      st_next.cnt = TMS_DIV_RST;
      st_next.lvl = 1'b0;
    end else begin
      st_next.cnt = st_reg.cnt + 3'h1;
      st_next.lvl = (st_next.cnt < TMS_DIV_W'(DIV / 2));
    end
  end

  always_ff @(posedge clk_in or negedge nrst_in) begin
    if (!nrst_in) begin
      st_reg <= '0;
    end else begin
      st_reg <= st_next;
    end
  end

  assign level_out = st_reg.lvl;
  assign wrap_out = (st_reg.cnt == TMS_DIV_W'(DIV - 1));
endmodule

/* File: tms_dev.sv */
// device end: mode decode, pa and switch control, clock gating, lock
//
// Function
// RULE1: all low, enable low/open: power-down
// RULE2: open enable equals keying OR shift
// RULE3: enable low with input high: idle
// RULE4: shift high, keying low: osc/loop, pa off
// RULE5: clock held low until amplitude reached
// RULE6: clock gated on at period boundary
// RULE7: lock within 250 us of clock start
// RULE8: keying high turns amplifier on
// RULE9: shift low closes switch, high opens
// RULE10: controller holds shift high during start
// RULE11: enable high, inputs low: up, switch closed
// RULE12: keying high, shift low: pa on, closed
// RULE13: idle keeps switch open
// RULE14: power-down keeps switch open
// RULE15: controller waits clock then lock before keying
// RULE16: controller drops keying before shift
// RULE17: shift low lower, high higher frequency
// RULE18: fsk end keeps shift high until idle
// RULE19: driven enable: up high, down low
// RULE20: clock is crystal/8, low in power-down
// RULE21: amplitude input, lock modelled by counter
`timescale 1ns/1ps
module tms_dev
  import tms_pkg::*;
#(
  parameter int LOCK_CYC = TMS_LOCK_CYC
) (
  // clock and reset
  input wire logic clk_in,
  input wire logic nrst_in,
  // pin side
  tms_if.dev pins,
  // analog status
  input wire logic amp_ok_in,
  // device state
  output tms_pkg::tms_mode_t mode_out,
  output logic osc_on_out,
  output logic pa_on_out,
  output logic switch_closed_out,
  output logic freq_high_out,
  output logic clk_active_out,
  output logic ready_out
);
  import tms_pkg::*;

  // whole device state: pin synchronisers, mode, gating and lock
  typedef struct packed {
    // first and second stage of each pin synchroniser
    logic ka;
    logic kb;
    logic fa;
    logic fb;
    logic ea;
    logic eb;
    logic oa;
    logic ob;
    logic aa;
    logic ab;
    // decoded mode and clock driver state
    tms_mode_t mode;
    logic clk_act;
    // lock timer, counts from clock driver start
    logic [TMS_CNT_W-1:0] lock_cnt;
    logic rdy;
    // amplifier, switch and frequency levels
    logic pa;
    logic sw_closed;
    logic fhi;
  } tms_dev_st_t;
  tms_dev_st_t st_reg, st_next;

  // synchronised pin levels
  logic keying;
  logic shift;
  logic en_lvl;
  logic en_oe;
  logic amp_ok;
  // internal enable and divider taps
  logic en_int;
  logic div_run;
  logic div_lvl;
  logic div_wrap;

  // second synchroniser stage feeds logic; the first stage is never
  // read, so a metastable sample cannot reach the decode
  assign keying = st_reg.kb;
  assign shift = st_reg.fb;
  assign en_lvl = st_reg.eb;
  assign en_oe = st_reg.ob;
  assign amp_ok = st_reg.ab;

  // RULE2: open enable follows inputs
  // an undriven enable pin reads as the OR of the other two
  assign en_int = en_oe ? en_lvl : (keying | shift);

  // divider runs only in power-up, so it restarts from zero each time
  assign div_run = (st_reg.mode == TMS_MODE_UP);

  tms_div u_div (
    .clk_in(clk_in),
    .nrst_in(nrst_in),
    .run_in(div_run),
    .level_out(div_lvl),
    .wrap_out(div_wrap)
  );

  ////////////////////////////////////////////////////////////////////////
  // next state
  always_comb begin
    st_next = st_reg;
    // two-stage synchronisers on pins
    st_next.ka = pins.pa_keying;
    st_next.kb = st_reg.ka;
    st_next.fa = pins.freq_shift;
    st_next.fb = st_reg.fa;
    st_next.ea = pins.enable_drv;
    st_next.eb = st_reg.ea;
    st_next.oa = pins.enable_oe;
    st_next.ob = st_reg.oa;
    // RULE21: amplitude level enters like a pin
    st_next.aa = amp_ok_in;
    st_next.ab = st_reg.aa;
    // mode decode: down, idle or up from synchronised pins
    // RULE1: power-down decode
    if (!keying && !shift && !en_int) begin
      st_next.mode = TMS_MODE_DOWN;
    // RULE3: idle when enable forced low
    end else if (!en_int) begin
      st_next.mode = TMS_MODE_IDLE;
    end else begin
      st_next.mode = TMS_MODE_UP;
    end

    // per-mode outputs; any mode but power-up forces safe levels
    case (st_reg.mode)
      TMS_MODE_UP: begin
        // RULE8: amplifier follows keying
        st_next.pa = keying;
        // RULE9: switch follows shift level
        st_next.sw_closed = !shift;
        // RULE17: frequency follows shift
        st_next.fhi = shift;
        // RULE6: gate on at period boundary
        // gating on the wrap keeps the first high half whole
        if (!st_reg.clk_act && amp_ok && div_wrap) begin
          st_next.clk_act = 1'b1;
        end
        // RULE21: lock timer as counter
        // counter stops at ready, so it never wraps back to zero
        // RULE7: count lock time after clock start
        if (st_reg.clk_act && !st_reg.rdy) begin
          if (st_reg.lock_cnt >= TMS_CNT_W'(LOCK_CYC - 1)) begin
            st_next.rdy = 1'b1;
          end else begin
            st_next.lock_cnt = st_reg.lock_cnt + 16'h0001;
          end
        end
      end
      default: begin
        // RULE13: idle opens switch
        // RULE14: power-down opens switch
        st_next.pa = 1'b0;
        st_next.sw_closed = 1'b0;
        st_next.fhi = 1'b0;
        st_next.clk_act = 1'b0;
        st_next.rdy = 1'b0;
        st_next.lock_cnt = TMS_CNT_RST;
      end
    endcase
    // leaving power-up drops everything at once, so no output
    // outlives the mode by a cycle
    if (st_next.mode != TMS_MODE_UP) begin
      st_next.fhi = 1'b0;
      st_next.pa = 1'b0;
      st_next.sw_closed = 1'b0;
      st_next.clk_act = 1'b0;
      st_next.rdy = 1'b0;
      st_next.lock_cnt = TMS_CNT_RST;
    end
  end

  // state register
  always_ff @(posedge clk_in or negedge nrst_in) begin
    if (!nrst_in) begin
      st_reg <= '0;
    end else begin
      st_reg <= st_next;
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // outputs
  // RULE4: osc and loop run in power-up
  // RULE11: power-up, switch closed when shift low
  // RULE12: amplifier on with switch closed
  assign osc_on_out = (st_reg.mode == TMS_MODE_UP);
  assign mode_out = st_reg.mode;
  assign pa_on_out = st_reg.pa;
  assign switch_closed_out = st_reg.sw_closed;
  assign freq_high_out = st_reg.fhi;
  assign clk_active_out = st_reg.clk_act;
  assign ready_out = st_reg.rdy;
  // pin clock: gate and divider level are both registered
  // RULE5: clock low until driver active
  // RULE20: divided clock, low in power-down
  assign pins.clk_out = st_reg.clk_act & div_lvl;
endmodule

/* File: tms_ctl.sv */
// controller end: start-up, keying and shutdown sequence on the pins
`timescale 1ns/1ps
module tms_ctl
  import tms_pkg::*;
#(
  parameter int XTAL_CYC = TMS_XTAL_CYC,
  parameter int LOCK_CYC = TMS_LOCK_CYC
) (
  // clock and reset
  input wire logic clk_in,
  input wire logic nrst_in,
  // user side
  input wire logic start_in,
  input wire logic use_enable_in,
  input wire logic fsk_mode_in,
  input wire logic data_in,
  input wire logic stop_in,
  output logic busy_out,
  output logic sending_out,
  output logic ext_clk_out,
  // pin side
  tms_if.ctl pins
);
  import tms_pkg::*;
  typedef enum logic [2:0] {
    ST_OFF, ST_WAKE, ST_LOCK, ST_SEND, ST_DROP
  } tms_ctl_state_t;
  typedef struct packed {
    tms_ctl_state_t state;
    logic [TMS_CNT_W-1:0] cnt;
    logic ca, cb;
    logic key, shift, en, en_oe, ext;
  } tms_ctl_st_t;
  tms_ctl_st_t st_reg, st_next;

  always_comb begin
    st_next = st_reg;
    st_next.ca = pins.clk_out;
    st_next.cb = st_reg.ca;
    case (st_reg.state)
      ST_OFF: begin
        st_next.key = 1'b0;
        st_next.shift = 1'b0;
        st_next.en = 1'b0;
        if (start_in) begin
          // RULE10: shift high during start
          // RULE19: driven enable high at start
          st_next.shift = 1'b1;
          st_next.en = use_enable_in;
          st_next.en_oe = use_enable_in;
          st_next.ext = 1'b1;
          st_next.cnt = TMS_CNT_RST;
          st_next.state = ST_WAKE;
        end
      end
      ST_WAKE: begin
        // RULE15: wait for clock before lock
        st_next.cnt = st_reg.cnt + 16'h0001;
        if (st_reg.cb || st_reg.cnt >= TMS_CNT_W'(XTAL_CYC)) begin
          st_next.cnt = TMS_CNT_RST;
          st_next.state = ST_LOCK;
        end
      end
      ST_LOCK: begin
        st_next.cnt = st_reg.cnt + 16'h0001;
        if (st_reg.cnt >= TMS_CNT_W'(LOCK_CYC)) begin
          st_next.state = ST_SEND;
        end
      end
      ST_SEND: begin
        // RULE17: fsk raises pa then toggles shift
        st_next.key = fsk_mode_in ? 1'b1 : data_in;
        st_next.shift = fsk_mode_in ? data_in : 1'b1;
        if (stop_in) begin
          // RULE16: drop keying first
          // RULE18: shift stays high meanwhile
          st_next.key = 1'b0;
          st_next.shift = 1'b1;
          st_next.ext = 1'b0;
          st_next.state = ST_DROP;
        end
      end
      ST_DROP: begin
        // RULE19: enable low and shift low
        st_next.shift = 1'b0;
        st_next.en = 1'b0;
        st_next.state = ST_OFF;
      end
      default: st_next.state = ST_OFF;
    endcase
  end

  always_ff @(posedge clk_in or negedge nrst_in) begin
    if (!nrst_in) begin
      st_reg <= '0;
    end else begin
      st_reg <= st_next;
    end
  end

  assign pins.pa_keying = st_reg.key;
  assign pins.freq_shift = st_reg.shift;
  assign pins.enable_drv = st_reg.en;
  assign pins.enable_oe = st_reg.en_oe;
  assign busy_out = (st_reg.state != ST_OFF);
  assign sending_out = (st_reg.state == ST_SEND);
  assign ext_clk_out = st_reg.ext;
endmodule

/* File: tms_assertions.sv */
// checker: timing rules on the control pins
`timescale 1ns/1ps
module tms_assertions
  import tms_pkg::*;
#(
  parameter int LOCK_CYC = TMS_LOCK_CYC
) (
  // clock and reset
  input wire logic clk_in,
  input wire logic nrst_in,
  // pins
  input wire logic pa_keying,
  input wire logic freq_shift,
  input wire logic enable_drv,
  input wire logic enable_oe,
  input wire logic clk_out
);
  import tms_pkg::*;
  logic up;
  logic [15:0] cnt_reg;
  // power-up request as the pins ask
  assign up = enable_oe ? enable_drv : (pa_keying | freq_shift);
  // cycles since clock output first seen
  always_ff @(posedge clk_in or negedge nrst_in) begin
    if (!nrst_in) begin
      cnt_reg <= 16'h0000;
    end else if (!up) begin
      cnt_reg <= 16'h0000;
    end else if ((clk_out || cnt_reg != 16'h0000) && cnt_reg != 16'hffff) begin
      cnt_reg <= cnt_reg + 16'h0001;
    end
  end
  default clocking cb @(posedge clk_in); endclocking
  default disable iff (!nrst_in);
  // half periods of the divided clock
  sequence s_high;
    clk_out [*3] ##1 !clk_out;
  endsequence
  sequence s_low;
    !clk_out [*3] ##1 clk_out;
  endsequence
  a_clk_low_down: assert property ((!up) [*8] |-> !clk_out)
    else $error("clock output active while powered down");
  a_clk_high_half: assert property ($rose(clk_out) ##1 up |-> s_high)
    else $error("clock high half not four cycles");
  a_clk_low_half: assert property ($fell(clk_out) ##1 up |-> s_low)
    else $error("clock low half not four cycles");
  a_clk_needs_up: assert property ($rose(clk_out) |-> $past(up, 3))
    else $error("clock started without power-up");
  a_key_enabled: assert property ($rose(pa_keying) |->
    freq_shift || (enable_oe && enable_drv))
    else $error("keying without enable held");
  a_key_after_lock: assert property ($rose(pa_keying) |->
    cnt_reg >= 16'(LOCK_CYC))
    else $error("keying before lock time");
  a_wake_shift: assert property ($rose(up) |-> freq_shift && !pa_keying)
    else $error("wake without shift high");
  a_drop_order: assert property ($fell(up) |-> !$past(pa_keying))
    else $error("power-down before keying dropped");
endmodule

/* File: tb.sv */
// testbench: both ends joined, pin decode table, keyed transfers
`timescale 1ns/1ps
module tb;
  import tms_pkg::*;
  localparam int LK = 20;
  logic clk_in = 1'b0;
  logic nrst_in = 1'b0;
  logic amp_ok = 1'b0;
  logic start = 1'b0;
  logic use_en = 1'b0;
  logic freq_shift_input = 1'b0;
  logic data = 1'b0;
  logic stop = 1'b0;
  logic busy, sending, ext_clk, osc, pa_on, sw, fh, clk_act, ready;
  logic osc2, pa2, sw2, fh2;
  logic [3:0] evs;
  tms_mode_t mode, mode2;
  int miscompares = 0;
  int checks = 0;
  int n;
  // pins, then mode, pa on, switch closed
  logic [7:0] rows [10] = '{8'h00, 8'h20, 8'h39, 8'h48, 8'h8b, 8'hca,
    8'h64, 8'ha4, 8'hfa, 8'he4};
  tms_if link_if();
  tms_if tbl_if();
  // design ends and checker
  tms_dev #(.LOCK_CYC(LK)) tms_dev_inst (.clk_in(clk_in), .nrst_in(nrst_in),
    .pins(link_if.dev), .amp_ok_in(amp_ok), .mode_out(mode),
    .osc_on_out(osc), .pa_on_out(pa_on), .switch_closed_out(sw),
    .freq_high_out(fh), .clk_active_out(clk_act), .ready_out(ready));
  tms_dev #(.LOCK_CYC(LK)) tms_dev_inst2 (.clk_in(clk_in), .nrst_in(nrst_in),
    .pins(tbl_if.dev), .amp_ok_in(amp_ok), .mode_out(mode2),
    .osc_on_out(osc2), .pa_on_out(pa2), .switch_closed_out(sw2),
    .freq_high_out(fh2), .clk_active_out(), .ready_out());
  tms_ctl #(.XTAL_CYC(50), .LOCK_CYC(LK)) tms_ctl_inst (.clk_in(clk_in),
    .nrst_in(nrst_in), .start_in(start), .use_enable_in(use_en),
    .fsk_mode_in(freq_shift_input), .data_in(data), .stop_in(stop), .busy_out(busy),
    .sending_out(sending), .ext_clk_out(ext_clk), .pins(link_if.ctl));
  tms_assertions #(.LOCK_CYC(LK)) tms_assertions_inst (.clk_in(clk_in),
    .nrst_in(nrst_in), .pa_keying(link_if.pa_keying),
    .freq_shift(link_if.freq_shift), .enable_drv(link_if.enable_drv),
    .enable_oe(link_if.enable_oe), .clk_out(link_if.clk_out));
  assign evs = {~busy, sending, ready, clk_act};
  // clock and watchdog
  always #12.5 clk_in = ~clk_in;
  initial begin
    repeat (3000) @(posedge clk_in);
    miscompares++;
    close_out();
  end
  task automatic tick(input int c);
    repeat (c) @(posedge clk_in);
    #2;
  endtask
  task automatic chk(input string nm, input logic [3:0] e,
    input logic [3:0] g);
    checks++;
    if (g !== e) begin
      miscompares++;
      $display("unexpected %s exp %h got %h", nm, e, g);
    end
  endtask
  task automatic wait_on(input int k, input int lim);
    n = 0;
    while (evs[k] !== 1'b1 && n < lim) begin
      tick(1);
      n++;
    end
  endtask
  task automatic run(input logic go);
    if (go) start = 1'b1;
    else stop = 1'b1;
    tick(1);
    start = 1'b0;
    stop = 1'b0;
  endtask
  task automatic close_out();
    $display("checks %0d miscompares %0d", checks, miscompares);
    if (miscompares == 0 && checks > 0) $display("Finished cleanly");
    else $display("Finished with errors");
    $finish;
  endtask
  // main sequence
  initial begin
    {tbl_if.pa_keying, tbl_if.freq_shift, tbl_if.enable_oe,
      tbl_if.enable_drv} = 4'h0;
    tick(8);
    nrst_in = 1'b1;
    tick(1);
    chk("rst", 4'h0, {osc, pa_on, sw, link_if.clk_out});
    $display("test reset done");
    foreach (rows[i]) begin
      {tbl_if.pa_keying, tbl_if.freq_shift, tbl_if.enable_oe,
        tbl_if.enable_drv} = rows[i][7:4];
      tick(8);
      chk("tbl mode", {2'b00, rows[i][3:2]},
        {2'b00, mode2});
      chk("tbl outs", {rows[i][3], rows[i][1:0], rows[i][3] & rows[i][6]},
        {osc2, pa2, sw2, fh2});
    end
    $display("test table done");
    data = 1'b1;
    run(1'b1);
    tick(10);
    chk("wake pins", 4'h4, {link_if.pa_keying, link_if.freq_shift,
      link_if.clk_out, clk_act});
    chk("wake dev", 4'h9, {osc, pa_on, sw, fh});
    amp_ok = 1'b1;
    wait_on(0, 40);
    chk("gate", 4'h1, 4'(n <= 12));
    wait_on(1, 100);
    chk("lock", 4'h1, 4'(n <= LK));
    wait_on(2, 200);
    tick(8);
    chk("ask on", 4'h3, {2'b00, pa_on, ext_clk});
    data = 1'b0;
    tick(8);
    chk("ask off", 4'h1, {2'b00, pa_on, ext_clk});
    run(1'b0);
    wait_on(3, 200);
    tick(8);
    chk("down", 4'h0, {osc, pa_on, link_if.clk_out, ext_clk});
    $display("test ask done");
    {use_en, freq_shift_input} = 2'h3;
    run(1'b1);
    wait_on(2, 300);
    tick(8);
    chk("fsk lo", 4'hb, {pa_on, fh, sw, link_if.enable_oe});
    data = 1'b1;
    tick(8);
    chk("fsk hi", 4'hd, {pa_on, fh, sw, link_if.enable_oe});
    run(1'b0);
    wait_on(3, 300);
    tick(8);
    chk("fsk down", {2'b00, TMS_MODE_DOWN}, {2'b00, mode});
    $display("test fsk done");
    // reset in mid start-up: osc, pa, busy, shift, clock, gate and mode back to reset levels
    {use_en, freq_shift_input} = 2'h0;
    run(1'b1);
    tick(6);
    nrst_in = 1'b0;
    tick(2);
    chk("mid rst", 4'h0, {osc, pa_on, busy, link_if.freq_shift});
    nrst_in = 1'b1;
    tick(2);
    chk("after rst", 4'h0, {osc, clk_act, busy, link_if.clk_out});
    chk("rst mode", {2'b00, TMS_MODE_DOWN}, {2'b00, mode});
    $display("test mid reset done");
    close_out();
  end
endmodule
